// >>> core/jil_top.sv
// Boundary-scan instruction logic: registers, pad control and offset crossing
`timescale 1ns/1ps
module jil_top (
    // Core clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Test access port
    input wire logic tck,
    input wire logic trstN,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoOeN,
    // Functional pads
    input wire logic [jil_pkg::NOUT-1:0] coreOut,
    input wire logic coreOe,
    input wire logic [jil_pkg::NIN-1:0] padIn,
    output logic [jil_pkg::NOUT-1:0] padOut,
    output logic [jil_pkg::NOUT-1:0] padOeN,
    // Flag offsets, core domain
    input wire logic [jil_pkg::OFF_W-1:0] almostEmptyOffset,
    input wire logic [jil_pkg::OFF_W-1:0] almostFullOffset,
    input wire logic serialProgActive,
    output logic offWrStb,
    output logic [jil_pkg::OFF_W-1:0] offWrEmpty,
    output logic [jil_pkg::OFF_W-1:0] offWrFull
);
    import jil_pkg::*;

    typedef struct packed {
        logic [IR_W-1:0] irShift;
        logic [IR_W-1:0] irCur;
        logic bypass;
        logic [ID_W-1:0] idShift;
        logic [BSR_LEN-1:0] bsrShift;
        logic [BSR_LEN-1:0] bsrUpd;
        logic [OFF_LEN-1:0] offShift;
        logic [OFF_LEN-1:0] offWrHold;
        logic [OFF_LEN-1:0] offRdShadow;
        logic offWrTgl;
        logic rdAckTgl;
        logic [SYNC_N-1:0] rdReqSync;
    } jil_tck_t;

    typedef struct packed {
        logic [OFF_LEN-1:0] rdSnap;
        logic rdReqTgl;
        logic [SYNC_N-1:0] ackSync;
        logic [SYNC_N-1:0] wrSync;
        logic wrSeen;
        logic [SYNC_N-1:0] spSync;
        logic spBusy;
        logic wrStb;
        logic [OFF_LEN-1:0] wrData;
    } jil_ref_t;

    localparam int SL = SYNC_N - 1;
    localparam int SM = SYNC_N - 2;

    jil_tap_if tap ();

    jil_tap_fsm u_fsm (
        .tck(tck),
        .trstN(trstN),
        .tms(tms),
        .tap(tap)
    );

    jil_tck_t t_ff;
    jil_tck_t nxt_t;
    jil_ref_t r_ff;
    jil_ref_t nxt_r;
    logic selBsr;
    logic selId;
    logic selOff;
    logic selByp;
    logic extDrive;
    logic rdReqNew;
    logic ackDone;
    logic wrNew;

    // Data register select from the current instruction
    always_comb begin
        selBsr = 1'b0;
        selId = 1'b0;
        selOff = 1'b0;
        selByp = 1'b0;
        unique case (t_ff.irCur)
            OP_EXTEST: selBsr = 1'b1;
            OP_SAMPLE: selBsr = 1'b1;
            OP_IDCODE: selId = 1'b1;
            OP_OFFRD: selOff = 1'b1;
            OP_OFFWR: selOff = 1'b1;
            OP_CLAMP: selByp = 1'b1;
            OP_HIGHZ: selByp = 1'b1;
            OP_BYPASS: selByp = 1'b1;
            default: selByp = 1'b1;
        endcase
    end

    // Stable toggle level only once the last two stages agree
    assign rdReqNew = (t_ff.rdReqSync[SM] == t_ff.rdReqSync[SL])
        && (t_ff.rdReqSync[SL] != t_ff.rdAckTgl);

    always_comb begin
        nxt_t = t_ff;
        nxt_t.rdReqSync = {t_ff.rdReqSync[SM:0], r_ff.rdReqTgl};
        if (tap.captureIr) begin
            nxt_t.irShift = IR_CAPTURE;
        end else if (tap.shiftIr) begin
            nxt_t.irShift = {tdi, t_ff.irShift[IR_W-1:1]};
        end
        if (tap.inReset) begin
            nxt_t.irCur = OP_IDCODE;
        end else if (tap.updateIr) begin
            nxt_t.irCur = t_ff.irShift;
        end
        if (tap.captureDr) begin
            if (selByp) begin
                nxt_t.bypass = 1'b0;
            end
            if (selId) begin
                nxt_t.idShift = ID_VALUE;
            end
            if (selBsr) begin
                nxt_t.bsrShift = {coreOe, coreOut, padIn};
            end
            if (selOff) begin
                nxt_t.offShift = t_ff.offRdShadow;
            end
        end else if (tap.shiftDr) begin
            if (selByp) begin
                nxt_t.bypass = tdi;
            end
            if (selId) begin
                nxt_t.idShift = {tdi, t_ff.idShift[ID_W-1:1]};
            end
            if (selBsr) begin
                nxt_t.bsrShift = {tdi, t_ff.bsrShift[BSR_LEN-1:1]};
            end
            if (selOff) begin
                nxt_t.offShift = {tdi, t_ff.offShift[OFF_LEN-1:1]};
            end
        end
        // Update cells change only under a boundary instruction, never under clamp
        if (tap.updateDr && selBsr) begin
            nxt_t.bsrUpd = t_ff.bsrShift;
        end
        if (tap.updateDr && (t_ff.irCur == OP_OFFWR)) begin
            nxt_t.offWrHold = t_ff.offShift;
            nxt_t.offWrTgl = ~t_ff.offWrTgl;
        end
        // Snapshot is stable here: the core side waits for this acknowledge
        if (rdReqNew) begin
            nxt_t.offRdShadow = r_ff.rdSnap;
            nxt_t.rdAckTgl = t_ff.rdReqSync[SL];
        end
    end

    always_ff @(posedge tck or negedge trstN) begin
        if (!trstN) begin
            t_ff <= '0;
            t_ff.irCur <= OP_IDCODE;
            t_ff.idShift <= ID_VALUE;
        end else begin
            t_ff <= nxt_t;
        end
    end

    // Serial output moves on the falling edge so the tester samples a settled bit
    always_ff @(negedge tck or negedge trstN) begin
        if (!trstN) begin
            tdo <= 1'b0;
            tdoOeN <= 1'b1;
        end else begin
            tdoOeN <= !(tap.shiftIr || tap.shiftDr);
            if (tap.shiftIr) begin
                tdo <= t_ff.irShift[0];
            end else if (selId) begin
                tdo <= t_ff.idShift[0];
            end else if (selBsr) begin
                tdo <= t_ff.bsrShift[0];
            end else if (selOff) begin
                tdo <= t_ff.offShift[0];
            end else begin
                tdo <= t_ff.bypass;
            end
        end
    end

    // Pad control; identity and bypass scans leave the functional path alone
    assign extDrive = (t_ff.irCur == OP_EXTEST) || (t_ff.irCur == OP_CLAMP);

    always_comb begin
        if (extDrive) begin
            padOut = t_ff.bsrUpd[BSR_OUT_LO +: NOUT];
            padOeN = {NOUT{~t_ff.bsrUpd[BSR_OE_BIT]}};
        end else if (t_ff.irCur == OP_HIGHZ) begin
            padOut = coreOut;
            padOeN = {NOUT{1'b1}};
        end else begin
            padOut = coreOut;
            padOeN = {NOUT{~coreOe}};
        end
    end

    // Core side of the offset crossing
    assign ackDone = (r_ff.ackSync[SM] == r_ff.ackSync[SL])
        && (r_ff.ackSync[SL] == r_ff.rdReqTgl);
    assign wrNew = (r_ff.wrSync[SM] == r_ff.wrSync[SL])
        && (r_ff.wrSync[SL] != r_ff.wrSeen);

    always_comb begin
        nxt_r = r_ff;
        nxt_r.ackSync = {r_ff.ackSync[SM:0], t_ff.rdAckTgl};
        nxt_r.wrSync = {r_ff.wrSync[SM:0], t_ff.offWrTgl};
        nxt_r.spSync = {r_ff.spSync[SM:0], serialProgActive};
        nxt_r.wrStb = 1'b0;
        if (r_ff.spSync[SM] == r_ff.spSync[SL]) begin
            nxt_r.spBusy = r_ff.spSync[SL];
        end
        if (ackDone) begin
            nxt_r.rdSnap = {almostFullOffset, almostEmptyOffset};
            nxt_r.rdReqTgl = ~r_ff.rdReqTgl;
        end
        // A write that meets an active serial port is dropped, not queued
        if (wrNew) begin
            nxt_r.wrSeen = r_ff.wrSync[SL];
            if (!r_ff.spBusy) begin
                nxt_r.wrStb = 1'b1;
                nxt_r.wrData = t_ff.offWrHold;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign offWrStb = r_ff.wrStb;
    assign offWrEmpty = r_ff.wrData[OFF_W-1:0];
    assign offWrFull = r_ff.wrData[OFF_LEN-1:OFF_W];

    a_reset_idcode: assert property (@(posedge tck) disable iff (!trstN)
        tap.inReset |=> (t_ff.irCur == OP_IDCODE))
        else $error("identification not current after reset");

    a_capture_ir: assert property (@(posedge tck) disable iff (!trstN)
        tap.captureIr |=> (t_ff.irShift[1:0] == IR_CAPTURE[1:0]))
        else $error("capture-ir pattern wrong");

    a_ir_hold: assert property (@(posedge tck) disable iff (!trstN)
        !tap.updateIr && !tap.inReset |=> $stable(t_ff.irCur))
        else $error("instruction changed outside update-ir");

    a_bypass_zero: assert property (@(posedge tck) disable iff (!trstN)
        tap.captureDr && selByp |=> !t_ff.bypass)
        else $error("bypass stage not zero after capture");

    a_id_capture: assert property (@(posedge tck) disable iff (!trstN)
        tap.captureDr && (t_ff.irCur == OP_IDCODE) |=> (t_ff.idShift == ID_VALUE))
        else $error("identity word not captured");

    a_id_shift: assert property (@(posedge tck) disable iff (!trstN)
        tap.captureDr && selId ##1 tap.shiftDr |=> (t_ff.idShift[0] == ID_VALUE[1]))
        else $error("identity word shifted out of order");

    a_bsr_path: assert property (@(posedge tck) disable iff (!trstN)
        tap.shiftDr && selBsr |=> (t_ff.bsrShift[BSR_LEN-1] == $past(tdi)))
        else $error("boundary chain not in serial path");

    a_extest_drive: assert property (@(posedge tck) disable iff (!trstN)
        (t_ff.irCur == OP_EXTEST) |-> (padOut == t_ff.bsrUpd[BSR_OUT_LO +: NOUT])
        && (padOeN == {NOUT{~t_ff.bsrUpd[BSR_OE_BIT]}}))
        else $error("external test not driving scanned values");

    a_clamp_stable: assert property (@(posedge tck) disable iff (!trstN)
        (t_ff.irCur == OP_CLAMP) && ($past(t_ff.irCur) == OP_CLAMP) |-> $stable(padOut))
        else $error("clamped outputs moved");

    a_highz_all: assert property (@(posedge tck) disable iff (!trstN)
        (t_ff.irCur == OP_HIGHZ) |-> (padOeN == {NOUT{1'b1}}))
        else $error("output enabled under high impedance");

    a_bypass_func: assert property (@(posedge tck) disable iff (!trstN)
        (t_ff.irCur == OP_BYPASS) |-> (padOut == coreOut) && (padOeN == {NOUT{~coreOe}}))
        else $error("bypass disturbed functional pads");

    a_offwr_hold: assert property (@(posedge tck) disable iff (!trstN)
        tap.updateDr && (t_ff.irCur == OP_OFFWR) |=> (t_ff.offWrHold == $past(t_ff.offShift))
        && (t_ff.offWrTgl != $past(t_ff.offWrTgl)))
        else $error("offset write not latched at update-dr");

    a_bsr_capture: assert property (@(posedge tck) disable iff (!trstN)
        tap.captureDr && selBsr |=> (t_ff.bsrShift[NIN-1:0] == $past(padIn)))
        else $error("pin inputs not captured");

    a_sample_func: assert property (@(posedge tck) disable iff (!trstN)
        (t_ff.irCur == OP_SAMPLE) |-> (padOut == coreOut) && (padOeN == {NOUT{~coreOe}}))
        else $error("sample disturbed functional pads");

    a_id_func: assert property (@(posedge tck) disable iff (!trstN)
        (t_ff.irCur == OP_IDCODE) |-> (padOut == coreOut) && (padOeN == {NOUT{~coreOe}}))
        else $error("identity scan disturbed functional pads");

    a_spare_func: assert property (@(posedge tck) disable iff (!trstN)
        selByp && (t_ff.irCur != OP_CLAMP) && (t_ff.irCur != OP_HIGHZ)
        |-> (padOut == coreOut) && (padOeN == {NOUT{~coreOe}}))
        else $error("bypass code disturbed functional pads");

    // Enable flop runs on the falling edge, so it is settled by the next rising edge
    a_shift_drive: assert property (@(posedge tck) disable iff (!trstN)
        (tap.shiftIr || tap.shiftDr) |-> !tdoOeN)
        else $error("serial output not driven while shifting");

    a_wr_strobe: assert property (@(posedge ref_clk) disable iff (rst)
        r_ff.wrStb |-> !$past(r_ff.spBusy) ##1 !r_ff.wrStb)
        else $error("offset strobe while serial port busy or held");

    c_extest_update: cover property (@(posedge tck) disable iff (!trstN)
        tap.updateDr && (t_ff.irCur == OP_EXTEST));
    c_id_scan: cover property (@(posedge tck) disable iff (!trstN)
        tap.captureDr && selId ##1 tap.shiftDr [*3]);
    c_offset_write: cover property (@(posedge ref_clk) disable iff (rst) r_ff.wrStb);
endmodule // jil_top

// >>> core/jil_pkg.sv
// Constants and types shared by the test-port instruction logic
package jil_pkg;
    // Instruction register
    localparam int IR_W = 4;
    localparam logic [IR_W-1:0] OP_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] OP_SAMPLE = 4'h1;
    localparam logic [IR_W-1:0] OP_IDCODE = 4'h2;
    localparam logic [IR_W-1:0] OP_CLAMP = 4'h3;
    localparam logic [IR_W-1:0] OP_HIGHZ = 4'h4;
    localparam logic [IR_W-1:0] OP_OFFRD = 4'h7;
    localparam logic [IR_W-1:0] OP_OFFWR = 4'h8;
    localparam logic [IR_W-1:0] OP_BYPASS = 4'hf;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    // Identification word, values arbitrary
    localparam int ID_W = 32;
    localparam logic [3:0] ID_VERSION = 4'h0;
    localparam logic [15:0] ID_PART = 16'h0a5c;
    localparam logic [10:0] ID_MFR = 11'h2aa;
    localparam logic ID_MARK = 1'b1;
    localparam logic [ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MFR, ID_MARK};
    // Boundary chain: inputs, outputs, one shared enable cell
    localparam int NIN = 4;
    localparam int NOUT = 4;
    localparam int BSR_OUT_LO = NIN;
    localparam int BSR_OE_BIT = NIN + NOUT;
    localparam int BSR_LEN = NIN + NOUT + 1;
    // Flag offset chain: full offset above empty offset
    localparam int OFF_W = 16;
    localparam int OFF_LEN = 2 * OFF_W;
    // Synchroniser depth
    localparam int SYNC_N = 3;
    // Controller states
    typedef enum logic [3:0] {
        TS_EX2_DR = 4'h0, TS_EX1_DR = 4'h1, TS_SH_DR = 4'h2, TS_PAUSE_DR = 4'h3,
        TS_SEL_IR = 4'h4, TS_UPD_DR = 4'h5, TS_CAP_DR = 4'h6, TS_SEL_DR = 4'h7,
        TS_EX2_IR = 4'h8, TS_EX1_IR = 4'h9, TS_SH_IR = 4'ha, TS_PAUSE_IR = 4'hb,
        TS_IDLE = 4'hc, TS_UPD_IR = 4'hd, TS_CAP_IR = 4'he, TS_RESET = 4'hf
    } jil_tap_state_t;
endpackage

// >>> core/jil_tap_if.sv
// Decoded controller strobes passed from the state machine to the data paths
`timescale 1ns/1ps
interface jil_tap_if;
    logic inReset;
    logic captureIr;
    logic shiftIr;
    logic updateIr;
    logic captureDr;
    logic shiftDr;
    logic updateDr;
    modport fsm (
        output inReset, captureIr, shiftIr, updateIr, captureDr, shiftDr, updateDr
    );
    modport core (
        input inReset, captureIr, shiftIr, updateIr, captureDr, shiftDr, updateDr
    );
endinterface

// >>> core/jil_tap_fsm.sv
// Test access port controller state machine on the test clock
`timescale 1ns/1ps
module jil_tap_fsm (
    // Test clock and reset
    input wire logic tck,
    input wire logic trstN,
    // Mode select
    input wire logic tms,
    // Decoded strobes
    jil_tap_if.fsm tap
);
    import jil_pkg::*;

    typedef struct packed {
        jil_tap_state_t st;
    } jil_fsm_t;

    jil_fsm_t q_ff;
    jil_fsm_t nxt_q;

    always_comb begin
        nxt_q = q_ff;
        unique case (q_ff.st)
            TS_RESET: nxt_q.st = tms ? TS_RESET : TS_IDLE;
            TS_IDLE: nxt_q.st = tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: nxt_q.st = tms ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: nxt_q.st = tms ? TS_EX1_DR : TS_SH_DR;
            TS_SH_DR: nxt_q.st = tms ? TS_EX1_DR : TS_SH_DR;
            TS_EX1_DR: nxt_q.st = tms ? TS_UPD_DR : TS_PAUSE_DR;
            TS_PAUSE_DR: nxt_q.st = tms ? TS_EX2_DR : TS_PAUSE_DR;
            TS_EX2_DR: nxt_q.st = tms ? TS_UPD_DR : TS_SH_DR;
            TS_UPD_DR: nxt_q.st = tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_IR: nxt_q.st = tms ? TS_RESET : TS_CAP_IR;
            TS_CAP_IR: nxt_q.st = tms ? TS_EX1_IR : TS_SH_IR;
            TS_SH_IR: nxt_q.st = tms ? TS_EX1_IR : TS_SH_IR;
            TS_EX1_IR: nxt_q.st = tms ? TS_UPD_IR : TS_PAUSE_IR;
            TS_PAUSE_IR: nxt_q.st = tms ? TS_EX2_IR : TS_PAUSE_IR;
            TS_EX2_IR: nxt_q.st = tms ? TS_UPD_IR : TS_SH_IR;
            TS_UPD_IR: nxt_q.st = tms ? TS_SEL_DR : TS_IDLE;
        endcase
    end

    always_ff @(posedge tck or negedge trstN) begin
        if (!trstN) begin
            q_ff.st <= TS_RESET;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign tap.inReset = (q_ff.st == TS_RESET);
    assign tap.captureIr = (q_ff.st == TS_CAP_IR);
    assign tap.shiftIr = (q_ff.st == TS_SH_IR);
    assign tap.updateIr = (q_ff.st == TS_UPD_IR);
    assign tap.captureDr = (q_ff.st == TS_CAP_DR);
    assign tap.shiftDr = (q_ff.st == TS_SH_DR);
    assign tap.updateDr = (q_ff.st == TS_UPD_DR);

    // Five high mode bits reach reset from anywhere, so the reset pin is optional
    a_tms_reset: assert property (@(posedge tck) disable iff (!trstN)
        tms [*5] |=> (q_ff.st == TS_RESET))
        else $error("five high tms did not reach reset");

    c_ir_update: cover property (@(posedge tck) disable iff (!trstN)
        (q_ff.st == TS_SH_IR) ##1 (q_ff.st == TS_EX1_IR) ##1 (q_ff.st == TS_UPD_IR));
endmodule // jil_tap_fsm

// >>> testbench/jil_tester.sv
// Boundary-scan tester model driving the test access port
`timescale 1ns/1ps
module jil_tester (
    // Test port drive
    output logic tck,
    output logic trstN,
    output logic tms,
    output logic tdi,
    // Test port return
    input wire logic tdo,
    input wire logic tdoOeN
);
    logic spare;
    int lowTicks;

    initial begin
        lowTicks = 0;
        tck = 1'b0;
        trstN = 1'b1;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One test clock; tdo taken just before the rising edge that shifts it
    task automatic tick(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #3;
        q = tdo;
        if (tdoOeN === 1'b0) begin
            lowTicks++;
        end
        tck = 1'b1;
        #3;
        tck = 1'b0;
    endtask

    // Clock stays still outside frames, so reset by pin needs no edges
    task automatic hardReset();
        trstN = 1'b0;
        #10;
        trstN = 1'b1;
        #3;
        tick(1'b0, ~tdi, spare);
    endtask

    task automatic tmsReset();
        repeat (5) tick(1'b1, ~tdi, spare);
        tick(1'b0, ~tdi, spare);
    endtask

    task automatic idle(input int n);
        repeat (n) tick(1'b0, ~tdi, spare);
    endtask

    // From Run-Test-Idle through one scan and back; tdi toggles when unused
    task automatic scan(input logic isIr, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        dout = '0;
        tick(1'b1, ~tdi, q);
        if (isIr) begin
            tick(1'b1, ~tdi, q);
        end
        tick(1'b0, ~tdi, q);
        tick(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tick(1'b1, ~tdi, q);
        tick(1'b0, ~tdi, q);
    endtask
endmodule // jil_tester

// >>> testbench/jil_top_bench.sv
// Self-checking bench for the test-port instruction logic
`timescale 1ns/1ps
module jil_top_bench;
    import jil_pkg::*;
    logic refClk, rst, tck, trstN, tms, tdi, tdo, tdoOeN;
    logic coreOe, serialProgActive, offWrStb, seen;
    logic [NOUT-1:0] coreOut, padOut, padOeN;
    logic [NIN-1:0] padIn;
    logic [OFF_W-1:0] aeOff, afOff, offWrEmpty, offWrFull;
    logic [31:0] got;
    int numErrors, checks;

    always #12.5 refClk = ~refClk;

    jil_top dut (.ref_clk(refClk), .rst(rst), .tck(tck), .trstN(trstN), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdoOeN(tdoOeN), .coreOut(coreOut), .coreOe(coreOe),
        .padIn(padIn), .padOut(padOut), .padOeN(padOeN), .almostEmptyOffset(aeOff),
        .almostFullOffset(afOff), .serialProgActive(serialProgActive),
        .offWrStb(offWrStb), .offWrEmpty(offWrEmpty), .offWrFull(offWrFull));

    jil_tester tester (.tck(tck), .trstN(trstN), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoOeN(tdoOeN));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] val);
        checks++;
        if (val !== exp) begin
            numErrors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, val);
        end
    endtask

    task automatic endSim();
        $display("checks %0d mismatches %0d", checks, numErrors);
        if (numErrors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic loadIr(input logic [IR_W-1:0] op);
        tester.scan(1'b1, IR_W, {28'h0, op}, got);
    endtask

    task automatic drScan(input int n, input logic [31:0] din);
        tester.scan(1'b0, n, din, got);
    endtask

    task automatic setPins(input logic [3:0] pin, input logic [3:0] out, input logic oe);
        @(negedge refClk);
        padIn = pin;
        coreOut = out;
        coreOe = oe;
    endtask

    // Strobe is one core cycle wide, so every cycle is looked at
    task automatic waitStb();
        seen = 1'b0;
        for (int i = 0; i < 40 && !seen; i++) begin
            @(negedge refClk);
            seen = (offWrStb === 1'b1);
        end
    endtask

    task automatic testIdent();
        setPins(4'hc, 4'h3, 1'b1);
        tester.hardReset();
        chk("tdo enable idle", 32'h1, {31'h0, tdoOeN});
        drScan(ID_W, 32'h0);
        chk("id after pin reset", ID_VALUE, got);
        chk("id marker bit", 32'h1, {31'h0, got[0]});
        chk("pads during id", 32'h3, {28'h0, padOut});
        chk("enable during id", 32'h0, {28'h0, padOeN});
        loadIr(OP_BYPASS);
        tester.tmsReset();
        drScan(ID_W, 32'h0);
        chk("id after tms reset", ID_VALUE, got);
        $display("test ident done");
    endtask

    task automatic testBypass();
        logic [3:0] codes [8];
        int base;
        codes = '{4'h5, 4'h6, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he};
        loadIr(OP_BYPASS);
        chk("ir capture", 32'h1, {30'h0, got[1:0]});
        base = tester.lowTicks;
        drScan(2, 32'h1);
        chk("bypass path", 32'h2, got);
        chk("tdo drive cycles", 32'h2, tester.lowTicks - base);
        foreach (codes[i]) begin
            loadIr(codes[i]);
            drScan(2, 32'h1);
            chk("spare code path", 32'h2, got);
            chk("spare code pads", 32'h3, {28'h0, padOut});
            chk("spare code enable", 32'h0, {28'h0, padOeN});
        end
        $display("test bypass done");
    endtask

    task automatic testBoundary();
        setPins(4'ha, 4'h5, 1'b1);
        loadIr(OP_SAMPLE);
        drScan(BSR_LEN, {23'h0, 1'b1, 4'h3, 4'h0});
        chk("sample capture", 32'ha, {28'h0, got[3:0]});
        chk("sample pad out", 32'h5, {28'h0, padOut});
        loadIr(OP_EXTEST);
        chk("extest preload out", 32'h3, {28'h0, padOut});
        chk("extest enable", 32'h0, {28'h0, padOeN});
        setPins(4'h6, 4'h5, 1'b1);
        drScan(BSR_LEN, {23'h0, 1'b0, 4'h9, 4'h0});
        chk("extest capture", 32'h6, {28'h0, got[3:0]});
        chk("extest new out", 32'h9, {28'h0, padOut});
        chk("extest off", 32'hf, {28'h0, padOeN});
        loadIr(OP_SAMPLE);
        drScan(BSR_LEN, {23'h0, 1'b1, 4'hb, 4'h0});
        loadIr(OP_CLAMP);
        chk("clamp out", 32'hb, {28'h0, padOut});
        drScan(2, 32'h3);
        chk("clamp bypass", 32'h2, got);
        chk("clamp held", 32'hb, {28'h0, padOut});
        chk("clamp enable", 32'h0, {28'h0, padOeN});
        loadIr(OP_HIGHZ);
        drScan(2, 32'h1);
        chk("highz bypass", 32'h2, got);
        chk("highz enable", 32'hf, {28'h0, padOeN});
        $display("test boundary done");
    endtask

    task automatic testOffset();
        @(negedge refClk);
        aeOff = 16'h1234;
        afOff = 16'hbeef;
        serialProgActive = 1'b0;
        loadIr(OP_OFFRD);
        tester.idle(100);
        drScan(OFF_LEN, 32'h0);
        chk("offset read", 32'hbeef1234, got);
        loadIr(OP_OFFWR);
        drScan(OFF_LEN, 32'h0f0e0d0c);
        waitStb();
        chk("write strobe", 32'h1, {31'h0, seen});
        if (seen !== 1'b1) begin
            endSim();
        end
        chk("write full", 32'h0f0e, {16'h0, offWrFull});
        chk("write empty", 32'h0d0c, {16'h0, offWrEmpty});
        serialProgActive = 1'b1;
        repeat (6) @(negedge refClk);
        drScan(OFF_LEN, 32'h11112222);
        waitStb();
        chk("write dropped", 32'h0, {31'h0, seen});
        serialProgActive = 1'b0;
        // Test port held still across the master reset
        rst = 1'b1;
        repeat (2) @(negedge refClk);
        rst = 1'b0;
        chk("reset clears data", 32'h0, {offWrFull, offWrEmpty});
        $display("test offset done");
    endtask

    initial begin
        refClk = 1'b0;
        rst = 1'b1;
        coreOut = '0;
        coreOe = 1'b0;
        padIn = '0;
        aeOff = '0;
        afOff = '0;
        serialProgActive = 1'b0;
        numErrors = 0;
        checks = 0;
        repeat (4) @(posedge refClk);
        @(negedge refClk);
        rst = 1'b0;
        testIdent();
        testBypass();
        testBoundary();
        testOffset();
        endSim();
    end
endmodule // jil_top_bench
